// ===== bench/ptg_top_bench.sv
// self-checking bench for the periodic tick generator
`timescale 1ns/1ps
module ptg_top_bench;
    import ptg_pkg::*;
    logic       clock_in;
    logic       arst_n_in;
    ptg_bus_s   bus;
    ptg_mode_s  mode;
    logic       int_clk;
    logic       ext_clk;
    logic       int_run;
    logic       ext_run;
    logic [7:0] rdata;
    logic [7:0] rv;
    logic       irq;
    logic       wake;
    logic [1:0] ph;
    int         n_mismatch;
    int         cmp_count;
    int         cyc;
    int         s;
    int         t1;
    int         t2;

    ptg_top u_dut (.clock_in(clock_in), .arst_n_in(arst_n_in),
        .bus_in(bus), .rdata_out(rdata), .mode_in(mode),
        .external_clock_in(ext_clk), .internal_clock_in(int_clk),
        .irq_out(irq), .wake_out(wake));

    initial begin
        clock_in = 1'b0;
        forever #20 clock_in = ~clock_in;
    end

    // sources toggle every two clocks and stand still when not running
    always @(posedge clock_in) begin
        cyc <= cyc + 1;
        ph <= ph + 2'h1;
        if (ph[0]) begin
            int_clk <= int_run & ~int_clk;
            ext_clk <= ext_run & ~ext_clk;
        end
        if (cyc >= 20000) begin
            n_mismatch++;
            results();
        end
    end

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %0t got %h want %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock_in);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clock_in);
        bus.wr <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clock_in);
        bus.addr <= a;
        bus.rd <= 1'b1;
        @(posedge clock_in);
        bus.rd <= 1'b0;
        #1 d = rdata;
    endtask

    // bounded wait; a missing interrupt counts as a mismatch
    task automatic wait_irq(output int t);
        t = -1;
        for (int i = 0; i < 300 && t < 0; i++) begin
            @(posedge clock_in);
            #1;
            if (irq === 1'b1) t = cyc;
        end
        if (t < 0) chk(8'h00, 8'h01);
    endtask

    task automatic results();
        $display("mismatches %0d compares %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    initial begin
        bus = '0;
        mode = '0;
        {int_clk, ext_clk, int_run, ext_run, ph} = '0;
        {n_mismatch, cmp_count, cyc} = '0;
        arst_n_in = 1'b0;
        repeat (20) @(posedge clock_in);
        arst_n_in <= 1'b1;
        repeat (3) @(posedge clock_in);
        rd(ADDR_CONTROL, rv);
        chk(rv, CONTROL_RESET);
        rd(ADDR_MASK, rv);
        chk(rv, MASK_RESET);
        rd(4'hF, rv);
        chk(rv, 8'h00);
        $display("test reset done");
        int_run <= 1'b1;
        wr(ADDR_CONTROL, 8'h72);
        repeat (60) @(posedge clock_in);
        #1 chk({7'h00, irq}, 8'h00);
        rd(ADDR_CONTROL, rv);
        chk(rv, 8'hF2);
        wr(ADDR_CONTROL, 8'h72);
        rd(ADDR_CONTROL, rv);
        chk(rv, 8'hF2);
        wr(ADDR_CONTROL, 8'h78);
        repeat (100) @(posedge clock_in);
        rd(ADDR_CONTROL, rv);
        chk(rv, 8'h70);
        $display("test flag and ack done");
        s = cyc;
        wr(ADDR_CONTROL, 8'h76);
        wait_irq(t1);
        chk({7'h00, t1 - s >= 8 && t1 - s <= 28}, 8'h01);
        wr(ADDR_CONTROL, 8'h7E);
        wait_irq(t2);
        chk(8'(t2 - t1), 8'h20);
        rd(ADDR_STATUS, rv);
        chk(rv, 8'h01);
        rd(ADDR_STATUS, rv);
        chk(rv, 8'h00);
        wr(ADDR_CONTROL, 8'h7A);
        wr(ADDR_MASK, 8'h01);
        wait_irq(t1);
        rd(ADDR_STATUS, rv);
        chk({7'h00, irq}, 8'h00);
        wr(ADDR_MASK, 8'h00);
        // rate changed only with the timebase stopped
        wr(ADDR_CONTROL, 8'h08);
        wr(ADDR_CONTROL, 8'h66);
        wait_irq(t1);
        wr(ADDR_CONTROL, 8'h6E);
        wait_irq(t2);
        chk(8'(t2 - t1), 8'h40);
        wr(ADDR_CONTROL, 8'h08);
        $display("test period and status done");
        wr(ADDR_CONTROL, 8'h7A);
        mode.wait_mode <= 1'b1;
        wr(ADDR_CONTROL, 8'h00);
        rd(ADDR_CONTROL, rv);
        chk(rv, 8'h00);
        repeat (60) @(posedge clock_in);
        mode.wait_mode <= 1'b0;
        rd(ADDR_CONTROL, rv);
        chk(rv, 8'hF2);
        $display("test wait mode done");
        wr(ADDR_CONTROL, 8'h78);
        int_run <= 1'b0;
        ext_run <= 1'b1;
        mode.ext_clock_on <= 1'b1;
        wr(ADDR_CONTROL, 8'h76);
        wait_irq(t1);
        chk({7'h00, t1 > 0}, 8'h01);
        wr(ADDR_CONTROL, 8'h7E);
        mode.osc_keep_in_stop <= 1'b1;
        mode.stop_mode <= 1'b1;
        rd(ADDR_CONTROL, rv);
        chk(rv, 8'h00);
        wait_irq(t1);
        chk({7'h00, wake}, 8'h01);
        mode.stop_mode <= 1'b0;
        $display("test clock source and stop done");
        results();
    end
endmodule // ptg_top_bench

// ===== inc/ptg_pkg.sv
// package of constants and types for the periodic tick generator
package ptg_pkg;
    localparam int STAGES = 15;
    localparam logic [3:0] ADDR_CONTROL = 4'h0;
    localparam logic [3:0] ADDR_STATUS  = 4'h1;
    localparam logic [3:0] ADDR_MASK    = 4'h2;
    // control register bit positions
    localparam int BIT_PEND  = 7;
    localparam int BIT_TAP_H = 6;
    localparam int BIT_TAP_L = 4;
    localparam int BIT_ACK   = 3;
    localparam int BIT_IEN   = 2;
    localparam int BIT_RUN   = 1;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] MASK_RESET    = 8'h00;
    localparam int EVT_TICK = 0;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } ptg_bus_s;

    typedef struct packed {
        logic ext_clock_on;
        logic wait_mode;
        logic stop_mode;
        logic osc_keep_in_stop;
    } ptg_mode_s;
endpackage

// ===== rtl/ptg_divider.sv
// divider chain with selectable rollover tap
`timescale 1ns/1ps
module ptg_divider #(
    parameter int STAGES_P = ptg_pkg::STAGES
) (
    input  wire logic       clock_in,
    input  wire logic       rst_n_in,
    input  wire logic       run_in,
    input  wire logic       step_in,
    input  wire logic [2:0] tap_in,
    output logic            roll_out
);
    import ptg_pkg::*;

    logic [STAGES_P-1:0] count;
    logic [STAGES_P-1:0] next_count;
    logic [3:0]          tap_bit;

    // tap index: the bit whose rising edge marks one period
    function automatic logic [3:0] tap_index(input logic [2:0] code);
        case (code)
            3'h0: tap_index = 4'hE; // 32768
            3'h1: tap_index = 4'hC; // 8192
            3'h2: tap_index = 4'hA; // 2048
            3'h3: tap_index = 4'h6; // 128
            3'h4: tap_index = 4'h5; // 64
            3'h5: tap_index = 4'h4; // 32
            3'h6: tap_index = 4'h3; // 16
            default: tap_index = 4'h2; // 8
        endcase
    endfunction

    assign tap_bit = tap_index(tap_in);
    assign next_count = count + STAGES_P'(1);
    // bit tap rises after half the period: first tick at half
    assign roll_out = run_in && step_in
        && !count[tap_bit] && next_count[tap_bit];

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            count <= '0;
        end else if (!run_in) begin
            count <= '0;
        end else if (step_in) begin
            count <= next_count;
        end
    end

    cleared_when_off_a: assert property (@(posedge clock_in)
        disable iff (!rst_n_in) !run_in |=> count == '0)
        else $error("divider not cleared while off");
    roll_needs_run_a: assert property (@(posedge clock_in)
        disable iff (!rst_n_in) roll_out |-> run_in && step_in)
        else $error("rollover without run and step");
endmodule // ptg_divider

// ===== rtl/ptg_top.sv
// periodic tick generator: control register, flag and interrupt
//
// Chosen here: the register addresses and the strobed register port.
`timescale 1ns/1ps
module ptg_top (
    input  wire logic             clock_in,
    input  wire logic             arst_n_in,
    input  wire ptg_pkg::ptg_bus_s  bus_in,
    output logic [7:0]            rdata_out,
    input  wire ptg_pkg::ptg_mode_s mode_in,
    input  wire logic             external_clock_in,
    input  wire logic             internal_clock_in,
    output logic                  irq_out,
    output logic                  wake_out
);
    import ptg_pkg::*;

    logic       rst_meta;
    logic       rst_n;
    logic       tick_run;
    logic       tick_irq_enable;
    logic [2:0] tap_select;
    logic       tick_pending_flag;
    logic [7:0] status;
    logic [7:0] mask;
    logic       src_meta;
    logic       src_sync;
    logic       src_prev;
    logic       active;
    logic       bus_open;
    logic       step;
    logic       roll;
    logic       wr_ctl;
    logic       wr_mask;
    logic       rd_ctl;
    logic       rd_stat;
    logic       rd_mask;
    logic       ack;
    logic [7:0] ctl_view;
    logic [7:0] next_rdata;
    logic       tick_source_clock;

    always_ff @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // source selection follows the clock generator enable
    assign tick_source_clock = mode_in.ext_clock_on
        ? external_clock_in : internal_clock_in;

    // source clock sampled as an enable; must run below clock_in / 2
    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            src_meta <= 1'b0;
            src_sync <= 1'b0;
            src_prev <= 1'b0;
        end else begin
            src_meta <= tick_source_clock;
            src_sync <= src_meta;
            src_prev <= src_sync;
        end
    end

    assign active = !mode_in.stop_mode || mode_in.osc_keep_in_stop;
    assign step = src_sync && !src_prev && active;
    assign bus_open = !mode_in.wait_mode && !mode_in.stop_mode;

    ptg_divider #(
        .STAGES_P (STAGES)
    ) u_div (
        .clock_in (clock_in),
        .rst_n_in (rst_n),
        .run_in   (tick_run),
        .step_in  (step),
        .tap_in   (tap_select),
        .roll_out (roll)
    );

    assign wr_ctl  = bus_open && bus_in.wr && bus_in.addr == ADDR_CONTROL;
    assign wr_mask = bus_open && bus_in.wr && bus_in.addr == ADDR_MASK;
    assign rd_ctl  = bus_open && bus_in.rd && bus_in.addr == ADDR_CONTROL;
    assign rd_stat = bus_open && bus_in.rd && bus_in.addr == ADDR_STATUS;
    assign rd_mask = bus_open && bus_in.rd && bus_in.addr == ADDR_MASK;
    assign ack = wr_ctl && bus_in.wdata[BIT_ACK];

    // acknowledge bit always reads zero
    assign ctl_view = {tick_pending_flag, tap_select, 1'b0,
                       tick_irq_enable, tick_run, 1'b0};
    assign next_rdata = rd_ctl  ? ctl_view :
                        rd_stat ? status :
                        rd_mask ? mask : 8'h00;

    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            tick_run        <= CONTROL_RESET[BIT_RUN];
            tick_irq_enable <= CONTROL_RESET[BIT_IEN];
            tap_select      <= CONTROL_RESET[BIT_TAP_H:BIT_TAP_L];
        end else if (wr_ctl) begin
            tick_run        <= bus_in.wdata[BIT_RUN];
            tick_irq_enable <= bus_in.wdata[BIT_IEN];
            // tap kept as written; software avoids changes while running
            tap_select      <= bus_in.wdata[BIT_TAP_H:BIT_TAP_L];
        end
    end

    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            tick_pending_flag <= 1'b0;
        end else if (roll) begin
            tick_pending_flag <= 1'b1;
        end else if (ack) begin
            tick_pending_flag <= 1'b0;
        end
    end

    // sticky event status, cleared by read; set wins over the clear
    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            status <= 8'h00;
            mask   <= MASK_RESET;
        end else begin
            if (roll) begin
                status[EVT_TICK] <= 1'b1;
            end else if (rd_stat) begin
                status[EVT_TICK] <= 1'b0;
            end
            status[7:1] <= 7'h00;
            if (wr_mask) begin
                mask <= bus_in.wdata;
            end
        end
    end

    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            rdata_out <= 8'h00;
        end else begin
            rdata_out <= next_rdata;
        end
    end

    assign irq_out = (tick_pending_flag && tick_irq_enable)
        || |(status & mask);
    // rollover in stop can wake the chip
    assign wake_out = irq_out && mode_in.stop_mode;

    irq_follows_a: assert property (@(posedge clock_in) disable iff (!rst_n)
        irq_out == ((tick_pending_flag && tick_irq_enable)
                    || |(status & mask)))
        else $error("interrupt output mismatch");
    roll_sets_a: assert property (@(posedge clock_in) disable iff (!rst_n)
        roll |=> tick_pending_flag)
        else $error("rollover did not set pending");
    ack_clears_a: assert property (@(posedge clock_in) disable iff (!rst_n)
        ack && !roll |=> !tick_pending_flag)
        else $error("acknowledge did not clear pending");
    zero_ack_a: assert property (@(posedge clock_in) disable iff (!rst_n)
        wr_ctl && !bus_in.wdata[BIT_ACK] && tick_pending_flag
        |=> tick_pending_flag)
        else $error("zero acknowledge cleared pending");
    ack_reads_zero_a: assert property (@(posedge clock_in)
        disable iff (!rst_n) rd_ctl |=> !rdata_out[BIT_ACK])
        else $error("acknowledge bit read as one");
    pend_readback_a: assert property (@(posedge clock_in)
        disable iff (!rst_n)
        rd_ctl |=> rdata_out[BIT_PEND] == $past(tick_pending_flag))
        else $error("pending readback wrong");
    wait_locked_a: assert property (@(posedge clock_in)
        disable iff (!rst_n)
        mode_in.wait_mode && bus_in.wr |=> $stable(tick_run))
        else $error("register written in wait");
    stop_idle_a: assert property (@(posedge clock_in) disable iff (!rst_n)
        mode_in.stop_mode && !mode_in.osc_keep_in_stop |-> !step)
        else $error("divider stepped in stop");
    race_keep_a: assert property (@(posedge clock_in) disable iff (!rst_n)
        roll && ack |=> tick_pending_flag)
        else $error("rollover lost to acknowledge");
endmodule // ptg_top
